// ---- rtl/slc_strap_latch.sv ----
`timescale 1ns/1ps
module slc_strap_latch (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [slc_pkg::NSTRAP-1:0] strap_pin_i,
  input wire logic [slc_pkg::NSTRAP-1:0] func_out_i,
  output logic [slc_pkg::NSTRAP-1:0] strap_pin_o,
  output logic [slc_pkg::NSTRAP-1:0] strap_pin_oe_o,
  output logic [slc_pkg::NSTRAP-1:0] strap_pull_up_o,
  output logic [slc_pkg::NSTRAP-1:0] strap_pull_dn_o,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic isolate_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic autoneg_enable_o,
  output logic addr0_broadcast_o,
  output logic pin_chain_test_o,
  output logic straps_valid_o
);
  import slc_pkg::*;

  logic [NSTRAP-1:0] strap_sync;
  logic [NSTRAP-1:0] strap_r;
  logic [NSTRAP-1:0] strap_nxt;
  logic latched_r;
  logic latched_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] adv_r;
  logic [15:0] adv_nxt;
  logic [15:0] mode_r;
  logic [15:0] mode_nxt;
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [31:0] wr_addr_r;
  logic [31:0] wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic bus_take;
  logic [31:0] rd_word;

  slc_sync #(
    .W(NSTRAP)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .clk_en_i(clk_en_i),
    .async_i(strap_pin_i),
    .sync_o(strap_sync)
  );

  // Pins are pulled inputs until the capture, then drive their function
  genvar gi;
  generate
    for (gi = 0; gi < NSTRAP; gi++) begin : g_pin
      assign strap_pin_o[gi] = latched_r ? func_out_i[gi] : 1'b0;
      assign strap_pin_oe_o[gi] = latched_r;
      assign strap_pull_up_o[gi] = !latched_r && STRAP_PULL_UP[gi];
      assign strap_pull_dn_o[gi] = !latched_r && !STRAP_PULL_UP[gi];
    end
  endgenerate

  assign bus_take = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr_i)
      CTRL_OFS: rd_word = {16'h0000, ctrl_r};
      ADV_OFS: rd_word = {16'h0000, adv_r};
      MODE_OFS: rd_word = {16'h0000, mode_r};
      STRAP_OFS: rd_word = {26'h000_0000, strap_r};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    strap_nxt = strap_r;
    latched_nxt = latched_r;
    ctrl_nxt = ctrl_r;
    adv_nxt = adv_r;
    mode_nxt = mode_r;
    wr_pend_nxt = wr_pend_r;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = rdata_r;
    if (clk_en_i) begin
      if (!latched_r) begin
        // Single capture on the first enabled cycle after reset release
        latched_nxt = 1'b1;
        strap_nxt = strap_sync;
        ctrl_nxt[CTRL_ISO_BIT] = strap_sync[STRAP_ISO];
        ctrl_nxt[CTRL_SPEED_BIT] = strap_sync[STRAP_SPEED];
        ctrl_nxt[CTRL_DUPLEX_BIT] = !strap_sync[STRAP_DUPLEX];
        ctrl_nxt[CTRL_ANEN_BIT] = strap_sync[STRAP_ANEN];
        adv_nxt[ADV_100HD_BIT] = strap_sync[STRAP_SPEED];
        adv_nxt[ADV_100FD_BIT] = strap_sync[STRAP_SPEED];
        adv_nxt[ADV_10HD_BIT] = 1'b1;
        adv_nxt[ADV_10FD_BIT] = 1'b1;
      end
      wr_pend_nxt = 1'b0;
      if (wr_pend_r) begin
        // Writes override strap values until next reset
        case (wr_addr_r)
          CTRL_OFS: ctrl_nxt = hwdata_i[15:0];
          ADV_OFS: adv_nxt = hwdata_i[15:0];
          MODE_OFS: mode_nxt = hwdata_i[15:0];
          default: ;
        endcase
      end
      if (bus_take) begin
        wr_pend_nxt = hwrite_i;
        wr_addr_nxt = haddr_i;
        if (!hwrite_i) begin
          rdata_nxt = rd_word;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      strap_r <= STRAP_PULL_UP;
      latched_r <= 1'b0;
      ctrl_r <= CTRL_RST;
      adv_r <= ADV_RST;
      mode_r <= MODE_RST;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
    end else begin
      strap_r <= strap_nxt;
      latched_r <= latched_nxt;
      ctrl_r <= ctrl_nxt;
      adv_r <= adv_nxt;
      mode_r <= mode_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata_o = rdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign isolate_o = ctrl_r[CTRL_ISO_BIT];
  assign speed_100_o = ctrl_r[CTRL_SPEED_BIT];
  assign full_duplex_o = ctrl_r[CTRL_DUPLEX_BIT];
  assign autoneg_enable_o = ctrl_r[CTRL_ANEN_BIT];
  // Unique when strap high or software bit set
  assign addr0_broadcast_o = !(strap_r[STRAP_BCOFF] || mode_r[MODE_BCOFF_BIT]);
  assign pin_chain_test_o = !strap_r[STRAP_TEST_N];
  assign straps_valid_o = latched_r;
endmodule : slc_strap_latch

// ---- inc/slc_pkg.sv ----
package slc_pkg;
  // Register indices; the bus sees each register at four times its index
  localparam logic [31:0] CTRL_IDX = 32'h0000_0000;
  localparam logic [31:0] ADV_IDX = 32'h0000_0004;
  localparam logic [31:0] MODE_IDX = 32'h0000_0016;
  localparam logic [31:0] CTRL_OFS = CTRL_IDX << 2;
  localparam logic [31:0] ADV_OFS = ADV_IDX << 2;
  localparam logic [31:0] MODE_OFS = MODE_IDX << 2;
  localparam logic [31:0] STRAP_OFS = 32'h0000_0100;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_ISO_BIT = 10;
  localparam int CTRL_ANEN_BIT = 12;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int ADV_10HD_BIT = 5;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_100HD_BIT = 7;
  localparam int ADV_100FD_BIT = 8;
  localparam int MODE_BCOFF_BIT = 9;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] ADV_RST = 16'h0001;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam int NSTRAP = 6;
  localparam int STRAP_ISO = 0;
  localparam int STRAP_SPEED = 1;
  localparam int STRAP_DUPLEX = 2;
  localparam int STRAP_ANEN = 3;
  localparam int STRAP_BCOFF = 4;
  localparam int STRAP_TEST_N = 5;
  localparam logic [NSTRAP-1:0] STRAP_PULL_UP = 6'h2E;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage : slc_pkg

// ---- rtl/slc_sync.sv ----
`timescale 1ns/1ps
module slc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (clk_en_i) begin
      meta_nxt = async_i;
      sync_nxt = meta_r;
    end
  end

  // No reset: pin levels keep flowing so the capture sees them, not a default
  always_ff @(posedge ref_clk_i) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_o = sync_r;
endmodule : slc_sync

// ---- dv/slc_board.sv ----
`timescale 1ns/1ps
module slc_board (
  input wire logic [slc_pkg::NSTRAP-1:0] fit_i,
  input wire logic [slc_pkg::NSTRAP-1:0] lvl_i,
  input wire logic [slc_pkg::NSTRAP-1:0] drv_i,
  input wire logic [slc_pkg::NSTRAP-1:0] oe_i,
  input wire logic [slc_pkg::NSTRAP-1:0] pu_i,
  output logic [slc_pkg::NSTRAP-1:0] pin_o
);
  import slc_pkg::*;
  // Device drive wins, else fitted resistor, else the weak internal pull
  assign pin_o = (oe_i & drv_i) | (~oe_i & ((fit_i & lvl_i) | (~fit_i & pu_i)));
endmodule : slc_board

// ---- dv/slc_checker.sv ----
`timescale 1ns/1ps
module slc_checker (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [slc_pkg::NSTRAP-1:0] strap_pin_i,
  input wire logic [slc_pkg::NSTRAP-1:0] strap_pin_oe_o,
  input wire logic [slc_pkg::NSTRAP-1:0] strap_pull_up_o,
  input wire logic [slc_pkg::NSTRAP-1:0] strap_pull_dn_o,
  input wire logic isolate_o,
  input wire logic speed_100_o,
  input wire logic full_duplex_o,
  input wire logic autoneg_enable_o,
  input wire logic addr0_broadcast_o,
  input wire logic pin_chain_test_o,
  input wire logic straps_valid_o
);
  import slc_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [NSTRAP-1:0] pin_q;
  logic [5:0] st;
  always_ff @(posedge ref_clk_i) pin_q <= strap_pin_i;
  assign st = {isolate_o, speed_100_o, full_duplex_o, autoneg_enable_o, addr0_broadcast_o,
    pin_chain_test_o};
  sequence released_s;
    !reset_i && $past(reset_i) && clk_en_i;
  endsequence
  capture_a: assert property (released_s |=> straps_valid_o) else $error("no capture");
  strap_map_a: assert property (released_s |=> st == {pin_q[0], pin_q[1], ~pin_q[2], pin_q[3],
    ~pin_q[4], ~pin_q[5]}) else $error("strap mapping wrong");
  valid_hold_a: assert property (straps_valid_o |=> straps_valid_o) else $error("valid fell");
  freeze_st_a: assert property (!clk_en_i |=> $stable(st)) else $error("moved while frozen");
  freeze_vld_a: assert property (!clk_en_i |=> $stable(straps_valid_o)) else $error("valid moved");
  pull_on_a: assert property (!straps_valid_o |-> strap_pin_oe_o == '0 &&
    strap_pull_up_o == STRAP_PULL_UP && strap_pull_dn_o == ~STRAP_PULL_UP) else $error("pulls wrong");
  drive_on_a: assert property (straps_valid_o |-> strap_pin_oe_o == '1) else $error("not driving");
  pull_off_a: assert property (straps_valid_o |-> (strap_pull_up_o | strap_pull_dn_o) == '0)
    else $error("pulls left on");
endmodule : slc_checker
bind slc_strap_latch slc_checker slc_checker_inst (.*);

// ---- dv/test_strap_latch_config.sv ----
`timescale 1ns/1ps
module test_strap_latch_config;
  import slc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'b00;
  logic [31:0] haddr_i = '0;
  logic [31:0] hwdata_i = '0;
  logic [31:0] hrdata_o, q;
  logic [NSTRAP-1:0] fit = '0, lvl = '0, fo = '0, pin, po, oe, pu, pd;
  logic rdy, resp, iso, spd, fd, an, bc, tst, vld;
  logic [NSTRAP-1:0] pats [4] = '{6'h00, 6'h3F, 6'h15, 6'h2A};
  int bad_count = 0;
  int compares = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  slc_board slc_board_inst (.fit_i(fit), .lvl_i(lvl), .drv_i(po), .oe_i(oe), .pu_i(pu), .pin_o(pin));
  slc_strap_latch slc_strap_latch_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .strap_pin_i(pin), .func_out_i(fo), .strap_pin_o(po),
    .strap_pin_oe_o(oe), .strap_pull_up_o(pu), .strap_pull_dn_o(pd), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(HSIZE_WORD),
    .hwdata_i(hwdata_i), .hready_i(rdy), .hrdata_o(hrdata_o), .hreadyout_o(rdy),
    .hresp_o(resp), .isolate_o(iso), .speed_100_o(spd), .full_duplex_o(fd),
    .autoneg_enable_o(an), .addr0_broadcast_o(bc), .pin_chain_test_o(tst), .straps_valid_o(vld));
  task automatic test_done;
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wt(input bit bus);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (((bus ? rdy : vld) !== 1'b1) && n < 50);
    if ((bus ? rdy : vld) !== 1'b1) begin
      bad_count++;
      test_done;
    end
  endtask : wt
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= HTRANS_NONSEQ;
    wt(1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    wt(1'b1);
    q = hrdata_o;
    chk("resp", 32'h0000_0000, {31'h0, resp});
  endtask : xfer
  task automatic boot(input logic [5:0] f, input logic [5:0] p, input logic [5:0] e);
    fit <= f;
    lvl <= p;
    fo <= '0;
    reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    wt(1'b0);
    fo <= ~e;
    lvl <= ~p;
    repeat (4) @(posedge ref_clk_i);
    chk("pins", {14'h0, 6'h3F, 12'h000}, {14'h0, oe, pu, pd});
    chk("pin_out", {26'h0, ~e}, {26'h0, po});
    chk("status", {26'h0, e[0], e[1], ~e[2], e[3], ~e[4], ~e[5]}, {26'h0, iso, spd, fd, an, bc, tst});
    xfer(1'b0, CTRL_OFS, '0);
    chk("ctrl", {18'h0, e[1], e[3], 1'b0, e[0], 1'b0, ~e[2], 8'h00}, q);
    xfer(1'b0, ADV_OFS, '0);
    chk("adv", {23'h0, e[1], e[1], 2'b11, 5'h01}, q);
  endtask : boot
  initial begin
    foreach (pats[i]) boot('1, pats[i], pats[i]);
    boot('0, '0, STRAP_PULL_UP);
    xfer(1'b1, CTRL_OFS, 32'h0000_3500);
    xfer(1'b1, MODE_OFS, 32'h0000_0200);
    @(posedge ref_clk_i);
    chk("override", 32'h0000_001E, {27'h0, iso, spd, fd, an, bc});
    xfer(1'b0, 32'h0000_0200, '0);
    chk("unmapped", 32'h0000_0000, q);
    clk_en_i <= 1'b0;
    xfer(1'b1, CTRL_OFS, 32'h0000_0000);
    clk_en_i <= 1'b1;
    xfer(1'b0, CTRL_OFS, '0);
    chk("frozen_ctrl", 32'h0000_3500, q);
    test_done;
  end
endmodule : test_strap_latch_config
